/* File: design/pel_pkg.sv */
// Constants for the event counter and indicator select register group
package pel_pkg;
  localparam int          CNT_W        = 16;
  localparam int          NUM_CNT      = 6;
  localparam int          ADDR_W       = 5;
  localparam int          SYM_RUN_LEN  = 6;
  localparam logic [2:0]  SYM_RUN_LAST = 3'h5;
  localparam logic [4:0]  ADDR_RX_DISCONNECT = 5'h14;
  localparam logic [4:0]  ADDR_RX_ERR_FRAME  = 5'h15;
  localparam logic [4:0]  ADDR_RX_SYM_ERR    = 5'h16;
  localparam logic [4:0]  ADDR_RX_EARLY_END  = 5'h17;
  localparam logic [4:0]  ADDR_RX_10M_EOF    = 5'h18;
  localparam logic [4:0]  ADDR_TX_JABBER     = 5'h19;
  localparam logic [4:0]  ADDR_LED_SELECT    = 5'h1b;
  localparam int          CNT_RX_DISCONNECT  = 0;
  localparam int          CNT_RX_ERR_FRAME   = 1;
  localparam int          CNT_RX_SYM_ERR     = 2;
  localparam int          CNT_RX_EARLY_END   = 3;
  localparam int          CNT_RX_10M_EOF     = 4;
  localparam int          CNT_TX_JABBER      = 5;
  localparam int          SEL_LSB            = 0;
  localparam int          SEL_W              = 3;
  localparam logic [2:0]  SEL_RESET          = 3'h0;
  localparam logic [15:0] CNT_RESET          = 16'h0000;
  localparam logic [15:0] CNT_MAX            = 16'hffff;
  localparam logic [15:0] CNT_ONE            = 16'h0001;
  localparam logic [15:0] READ_ZERO          = 16'h0000;
  typedef enum logic [2:0] {
    SEL_ACT_LINK  = 3'h0,
    SEL_SPD_COL   = 3'h1,
    SEL_SPD_LINK  = 3'h2,
    SEL_ACT_COL   = 3'h3,
    SEL_OFF_OFF   = 3'h4,
    SEL_OFF_ON    = 3'h5,
    SEL_ON_OFF    = 3'h6,
    SEL_ON_ON     = 3'h7
  } pel_sel_t;
endpackage

/* File: design/pel_cnt_if.sv */
// Carrier between the register front end and the counter bank
`timescale 1ns/100ps
interface pel_cnt_if;
  logic [pel_pkg::NUM_CNT-1:0] evt;
  logic [pel_pkg::NUM_CNT-1:0] clr;
  logic [pel_pkg::CNT_W-1:0]   count [pel_pkg::NUM_CNT];
  modport ctl  (output evt, output clr, input count);
  modport bank (input evt, input clr, output count);
endinterface

/* File: design/pel_counter_bank.sv */
// Bank of saturating clear-on-read event counters
`timescale 1ns/100ps
module pel_counter_bank (
  input  wire logic ref_clk,
  input  wire logic reset,
  pel_cnt_if.bank   cnt
);
  for (genvar i = 0; i < pel_pkg::NUM_CNT; i++) begin : g_cnt
    logic [pel_pkg::CNT_W-1:0] count_q;
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        count_q <= pel_pkg::CNT_RESET;
      end else if (cnt.clr[i]) begin
        // An event in the clearing cycle survives as a count of one
        count_q <= cnt.evt[i] ? pel_pkg::CNT_ONE : pel_pkg::CNT_RESET;
      end else if (cnt.evt[i] && count_q != pel_pkg::CNT_MAX) begin
        count_q <= count_q + pel_pkg::CNT_ONE;
      end
    end
    assign cnt.count[i] = count_q;
  end
endmodule // pel_counter_bank

/* File: design/pel_phy_error_counters_led_map.sv */
// Event counters and indicator source select of the transceiver
// How it works
// - Count each receive disconnect event, 16 bits
// - Repeater mode: frame without JK counts disconnect
// - Counters saturate at all ones, never wrap
// - Read clears counter; counters ignore writes
// - Error frame counter: once per errored frame
// - Each run of up to six bad symbols adds one count, on its first
// - Count frames ending without end delimiter
// - Count 10 Mb receive end-of-frame errors
// - Count 10 Mb transmit jabber detections
// - Select codes 0-3 pick indicator sources
// - Codes 4-7 force indicators; resets to 000
// - With select code 0 or 2, link indicator high until link valid, low after
`timescale 1ns/100ps
module pel_phy_error_counters_led_map (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        repeater_mode,
  input  wire logic        rx_disconnect_evt,
  input  wire logic        rx_frame_start_no_jk,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_err_cond,
  input  wire logic        rx_symbol_valid,
  input  wire logic        rx_symbol_bad,
  input  wire logic        rx_early_end_evt,
  input  wire logic        rx_10m_eof_err_evt,
  input  wire logic        tx_jabber_evt,
  input  wire logic        activity,
  input  wire logic        link_up,
  input  wire logic        speed_100,
  input  wire logic        collision,
  output logic             activity_indicator_out_n,
  output logic             link_indicator_out_n
);
  pel_cnt_if cnt ();

  pel_counter_bank u_bank (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cnt     (cnt.bank)
  );

  logic [pel_pkg::SEL_W-1:0] indicator_source_select_q;
  logic                      frame_err_q;
  logic [2:0]                sym_run_q;
  logic                      sym_bad_run;
  logic [15:0]               rd_value;
  logic                      rd_hit_cnt;
  logic [pel_pkg::NUM_CNT-1:0] rd_sel;
  logic                      act_src;
  logic                      link_src;

  // Errors seen mid-frame are held so that the frame counts once at its end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frame_err_q <= 1'b0;
    end else if (rx_frame_end) begin
      frame_err_q <= 1'b0;
    end else if (rx_err_cond) begin
      frame_err_q <= 1'b1;
    end
  end

  // Run position of bad symbols; first of every six is counted so a lone error still shows
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sym_run_q <= 3'h0;
    end else if (rx_frame_end) begin
      sym_run_q <= 3'h0;
    end else if (rx_symbol_valid) begin
      if (!rx_symbol_bad || sym_run_q == pel_pkg::SYM_RUN_LAST) begin
        sym_run_q <= 3'h0;
      end else begin
        sym_run_q <= sym_run_q + 3'h1;
      end
    end
  end

  assign sym_bad_run = rx_symbol_valid && rx_symbol_bad && (sym_run_q == 3'h0);

  assign cnt.evt[pel_pkg::CNT_RX_DISCONNECT] = rx_disconnect_evt
                                             || (repeater_mode && rx_frame_start_no_jk);
  assign cnt.evt[pel_pkg::CNT_RX_ERR_FRAME]  = rx_frame_end && (frame_err_q || rx_err_cond);
  assign cnt.evt[pel_pkg::CNT_RX_SYM_ERR]    = sym_bad_run;
  assign cnt.evt[pel_pkg::CNT_RX_EARLY_END]  = rx_early_end_evt;
  assign cnt.evt[pel_pkg::CNT_RX_10M_EOF]    = rx_10m_eof_err_evt;
  assign cnt.evt[pel_pkg::CNT_TX_JABBER]     = tx_jabber_evt;

  always_comb begin
    rd_sel = '0;
    unique case (reg_addr)
      pel_pkg::ADDR_RX_DISCONNECT: rd_sel[pel_pkg::CNT_RX_DISCONNECT] = 1'b1;
      pel_pkg::ADDR_RX_ERR_FRAME:  rd_sel[pel_pkg::CNT_RX_ERR_FRAME]  = 1'b1;
      pel_pkg::ADDR_RX_SYM_ERR:    rd_sel[pel_pkg::CNT_RX_SYM_ERR]    = 1'b1;
      pel_pkg::ADDR_RX_EARLY_END:  rd_sel[pel_pkg::CNT_RX_EARLY_END]  = 1'b1;
      pel_pkg::ADDR_RX_10M_EOF:    rd_sel[pel_pkg::CNT_RX_10M_EOF]    = 1'b1;
      pel_pkg::ADDR_TX_JABBER:     rd_sel[pel_pkg::CNT_TX_JABBER]     = 1'b1;
      default:                     rd_sel = '0;
    endcase
  end

  assign rd_hit_cnt = |rd_sel;
  assign cnt.clr    = reg_rd ? rd_sel : '0;

  always_comb begin
    rd_value = pel_pkg::READ_ZERO;
    for (int i = 0; i < pel_pkg::NUM_CNT; i++) begin
      if (rd_sel[i]) begin
        rd_value = cnt.count[i];
      end
    end
    if (reg_addr == pel_pkg::ADDR_LED_SELECT) begin
      rd_value = {13'h0000, indicator_source_select_q};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= pel_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_value;
    end
  end

  // Reserved bits are not stored, so they read back as zero whatever is written
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      indicator_source_select_q <= pel_pkg::SEL_RESET;
    end else if (reg_wr && reg_addr == pel_pkg::ADDR_LED_SELECT && !rd_hit_cnt) begin
      indicator_source_select_q <= reg_wdata[pel_pkg::SEL_LSB +: pel_pkg::SEL_W];
    end
  end

  always_comb begin
    act_src  = 1'b0;
    link_src = 1'b0;
    unique case (pel_pkg::pel_sel_t'(indicator_source_select_q))
      pel_pkg::SEL_ACT_LINK: begin
        act_src  = activity;
        link_src = link_up;
      end
      pel_pkg::SEL_SPD_COL: begin
        act_src  = speed_100;
        link_src = collision;
      end
      pel_pkg::SEL_SPD_LINK: begin
        act_src  = speed_100;
        link_src = link_up;
      end
      pel_pkg::SEL_ACT_COL: begin
        act_src  = activity;
        link_src = collision;
      end
      pel_pkg::SEL_OFF_OFF: begin
        act_src  = 1'b0;
        link_src = 1'b0;
      end
      pel_pkg::SEL_OFF_ON: begin
        act_src  = 1'b0;
        link_src = 1'b1;
      end
      pel_pkg::SEL_ON_OFF: begin
        act_src  = 1'b1;
        link_src = 1'b0;
      end
      pel_pkg::SEL_ON_ON: begin
        act_src  = 1'b1;
        link_src = 1'b1;
      end
    endcase
  end

  // Indicators are active low; off after reset until a source turns them on
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      activity_indicator_out_n <= 1'b1;
      link_indicator_out_n     <= 1'b1;
    end else begin
      activity_indicator_out_n <= ~act_src;
      link_indicator_out_n     <= ~link_src;
    end
  end
endmodule // pel_phy_error_counters_led_map

/* File: bench/pel_asserts.sv */
// Checker for counter reads and indicator selection
`timescale 1ns/100ps
module pel_asserts (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic        tx_jabber_evt,
  input wire logic        activity,
  input wire logic        link_up,
  input wire logic        speed_100,
  input wire logic        collision,
  input wire logic        activity_indicator_out_n,
  input wire logic        link_indicator_out_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [2:0] sel_q;
  logic [1:0] led_d;
  logic       rj, wl;
  assign rj = reg_rd && reg_addr == pel_pkg::ADDR_TX_JABBER;
  assign wl = reg_wr && reg_addr == pel_pkg::ADDR_LED_SELECT;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sel_q <= pel_pkg::SEL_RESET;
    else if (wl) sel_q <= reg_wdata[2:0];
  end
  // Forced codes 4-7 map straight onto the inverted low two bits
  always_comb begin
    case (sel_q)
      3'h0: led_d = {!activity, !link_up};
      3'h1: led_d = {!speed_100, !collision};
      3'h2: led_d = {!speed_100, !link_up};
      3'h3: led_d = {!activity, !collision};
      default: led_d = ~sel_q[1:0];
    endcase
  end
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[5'h14:5'h19], 5'h1b}) |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_read_clears: assert property (rj && !tx_jabber_evt ##1 rj |=> reg_rdata == 16'h0)
    else $error("counter not cleared by read");
  a_evt_kept: assert property (rj && tx_jabber_evt ##1 rj |=> reg_rdata == 16'h1)
    else $error("event lost in read cycle");
  a_led_map: assert property (1'b1 |=> {activity_indicator_out_n, link_indicator_out_n} == $past(led_d))
    else $error("indicator source wrong");
  a_force_on: assert property (wl && reg_wdata[2:0] == 3'h7 |-> ##2 !activity_indicator_out_n && !link_indicator_out_n)
    else $error("indicators not forced on");
  a_force_off: assert property (wl && reg_wdata[2:0] == 3'h4 |-> ##2 activity_indicator_out_n && link_indicator_out_n)
    else $error("indicators not forced off");
  a_link_wait: assert property (sel_q == 3'h0 && !link_up |=> link_indicator_out_n)
    else $error("link indicator on without link");
  c_back_read: cover property (rj ##1 rj);
  c_sel_write: cover property (wl);
  c_saturated: cover property (reg_rdata == 16'hffff);
endmodule // pel_asserts
bind pel_phy_error_counters_led_map pel_asserts u_asserts (.*);

/* File: bench/pel_mgmt_station.sv */
// Management station model on the register strobe port
`timescale 1ns/100ps
module pel_mgmt_station (
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [4:0]  reg_addr,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata
);
  initial begin
    {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
  end
  // Idle address is inverted so a stale value is never trusted
  task automatic rd(input logic [4:0] a, input int n, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    repeat (n) @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [2:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = {13'h0, v};
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // pel_mgmt_station

/* File: bench/test_phy_error_counters_led_map.sv */
// Self-checking bench for the event counter and indicator select group
`timescale 1ns/100ps
module test_phy_error_counters_led_map;
  logic        ref_clk = 1'b0, reset = 1'b1, rpt = 1'b0, act_n, link_n, reg_rd, reg_wr;
  logic [8:0]  ev = 9'h0;
  logic [3:0]  src = 4'h0;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] exp_c [6] = '{16'h5, 16'h1, 16'h2, 16'h4, 16'h5, 16'h6};
  int          fails = 0, checks = 0, cyc = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  pel_mgmt_station u_station (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  pel_phy_error_counters_led_map u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .repeater_mode(rpt),
    .rx_disconnect_evt(ev[0]), .rx_frame_start_no_jk(ev[1]), .rx_frame_end(ev[2]), .rx_err_cond(ev[3]),
    .rx_symbol_valid(ev[4]), .rx_symbol_bad(ev[5]), .rx_early_end_evt(ev[6]), .rx_10m_eof_err_evt(ev[7]),
    .tx_jabber_evt(ev[8]), .activity(src[3]), .link_up(src[2]), .speed_100(src[1]), .collision(src[0]),
    .activity_indicator_out_n(act_n), .link_indicator_out_n(link_n));
  function automatic logic [1:0] led(input logic [2:0] m, input logic [3:0] s);
    case (m)
      3'h0: return ~{s[3], s[2]};
      3'h1: return ~{s[1], s[0]};
      3'h2: return ~{s[1], s[2]};
      3'h3: return ~{s[3], s[0]};
      default: return ~m[1:0];
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input logic [8:0] b, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      ev = b;
      @(negedge ref_clk);
      ev = 9'h0;
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Saturation run dominates, so the ceiling sits well above it
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    for (int a = 5'h14; a <= 5'h1b; a++) begin
      u_station.rd(a[4:0], 1, d);
      chk("reset value", 16'h0, d);
    end
    $display("test reset done");
    pulse(9'h001, 3);
    rpt = 1'b1;
    pulse(9'h002, 2);
    rpt = 1'b0;
    pulse(9'h002, 2);
    pulse(9'h008, 2);
    pulse(9'h004, 2);
    pulse(9'h030, 7);
    pulse(9'h040, 4);
    pulse(9'h080, 5);
    pulse(9'h100, 6);
    u_station.wr(5'h19, 3'h1);
    for (int i = 0; i < 6; i++) begin
      u_station.rd(5'h14 + i[4:0], 1, d);
      chk("count", exp_c[i], d);
      u_station.rd(5'h14 + i[4:0], 1, d);
      chk("count after read", 16'h0, d);
    end
    $display("test counters done");
    // A good symbol restarts the symbol run; an error in the frame end cycle still counts
    pulse(9'h00c, 1);
    pulse(9'h030, 3);
    pulse(9'h010, 1);
    pulse(9'h030, 3);
    u_station.rd(5'h15, 1, d);
    chk("error frames", 16'h1, d);
    u_station.rd(5'h16, 1, d);
    chk("symbol runs", 16'h2, d);
    $display("test symbol runs done");
    ev = 9'h100;
    repeat (65540) @(negedge ref_clk);
    ev = 9'h0;
    u_station.rd(5'h19, 1, d);
    chk("saturated", 16'hffff, d);
    ev = 9'h100;
    u_station.rd(5'h19, 2, d);
    chk("event in read", 16'h1, d);
    ev = 9'h0;
    u_station.rd(5'h19, 2, d);
    chk("read clears", 16'h0, d);
    $display("test saturation done");
    for (int p = 0; p < 2; p++) begin
      src = p ? 4'h6 : 4'h9;
      for (int m = 0; m < 8; m++) begin
        u_station.wr(5'h1b, m[2:0]);
        u_station.rd(5'h1b, 1, d);
        chk("select", {13'h0, m[2:0]}, d);
        chk("indicators", {14'h0, led(m[2:0], src)}, {14'h0, act_n, link_n});
      end
    end
    $display("test indicators done");
    results();
  end
endmodule // test_phy_error_counters_led_map
